// File: hw/cell_select_consts.vh
// Purpose: Constants for the logic cell input selection stage
// Assumes: Plain Verilog-2005, included by bare name
// Notes:   Select codes are 6 bits wide
`ifndef CELL_SELECT_CONSTS_VH
`define CELL_SELECT_CONSTS_VH

// Field layout
`define SEL_W            6
`define SEL_RST          6'h00
`define MUX_COUNT        4

// Select codes
`define CODE_SYNC_DATA   6'h16
`define CODE_ZERO_CROSS  6'h17
`define CODE_ASYNC_TX    6'h18
`define CODE_ASYNC_RX    6'h19
`define CODE_TMR0_OVF    6'h1A
`define CODE_TMR1_OVF    6'h1B
`define CODE_TMR3_OVF    6'h1C
`define CODE_TMR5_OVF    6'h1D
`define CODE_TMR2_POST   6'h1E
`define CODE_TMR4_POST   6'h1F
`define CODE_TMR6_POST   6'h20
`define CODE_PIN_CHANGE  6'h21
`define CODE_CONV_RC     6'h22
`define CODE_SLOW_OSC    6'h23
`define CODE_FAST_OSC    6'h24
`define CODE_SYS_OSC     6'h25
`define CODE_MODULATOR   6'h26

// Modulator source per instance: 0 none, 1 first, 2 second
`define MOD_NONE         2'h0
`define MOD_ONE          2'h1
`define MOD_TWO          2'h2

`endif

// File: hw/select_reg.v
// Purpose: One software-writable 6-bit selection register
// Assumes: Write strobe and data come from logic on clk
// Notes:   Takes new value any time, no stop needed
`include "cell_select_consts.vh"
`default_nettype none

module select_reg (
    // Clock and reset
    input  wire       clk,
    input  wire       rstn,
    // Write side
    input  wire       wr_en,
    input  wire [5:0] wr_data,
    // Stored field
    output reg  [5:0] sel_r
);

    // Load on write, on the fly
    always @(posedge clk) begin
        if (!rstn) begin
            sel_r <= `SEL_RST;
        end else if (wr_en) begin
            sel_r <= wr_data;
        end
    end

endmodule // select_reg

`default_nettype wire

// File: hw/source_mux.v
// Purpose: One selection multiplexer over the internal candidate inputs
// Assumes: Candidate inputs are on clk's domain or plain levels
// Notes:   Combinational path, unknown codes give zero
`include "cell_select_consts.vh"
`default_nettype none

module source_mux (
    // Selection
    input  wire [5:0] mux_select_field,
    // Candidate sources
    input  wire       sys_osc,
    input  wire       fast_internal_osc,
    input  wire       slow_internal_osc,
    input  wire       converter_rc_clock,
    input  wire       pin_change_flag,
    input  wire       tmr2_post,
    input  wire       tmr4_post,
    input  wire       tmr6_post,
    input  wire       tmr0_ovf,
    input  wire       tmr1_ovf,
    input  wire       tmr3_ovf,
    input  wire       tmr5_ovf,
    input  wire       async_tx,
    input  wire       async_rx,
    input  wire       sync_data,
    input  wire       zero_cross_detector,
    input  wire       modulator_src,
    input  wire       modulator_ok,
    // Selected line
    output reg        data_line
);

    // Code decode to one source
    always @* begin
        case (mux_select_field)
            `CODE_SYS_OSC:    data_line = sys_osc;             // [RL7]
            `CODE_FAST_OSC:   data_line = fast_internal_osc;   // [RL7]
            `CODE_SLOW_OSC:   data_line = slow_internal_osc;   // [RL7]
            `CODE_CONV_RC:    data_line = converter_rc_clock;  // [RL7]
            `CODE_TMR2_POST:  data_line = tmr2_post;           // [RL8]
            `CODE_TMR4_POST:  data_line = tmr4_post;           // [RL8]
            `CODE_TMR6_POST:  data_line = tmr6_post;           // [RL8]
            `CODE_TMR0_OVF:   data_line = tmr0_ovf;            // [RL9]
            `CODE_TMR1_OVF:   data_line = tmr1_ovf;            // [RL9]
            `CODE_TMR3_OVF:   data_line = tmr3_ovf;            // [RL9]
            `CODE_TMR5_OVF:   data_line = tmr5_ovf;            // [RL9]
            `CODE_PIN_CHANGE: data_line = pin_change_flag;     // [RL10]
            `CODE_ASYNC_TX:   data_line = async_tx;            // [RL11]
            `CODE_ASYNC_RX:   data_line = async_rx;            // [RL11]
            `CODE_SYNC_DATA:  data_line = sync_data;           // [RL11]
            `CODE_ZERO_CROSS: data_line = zero_cross_detector; // [RL12]
            `CODE_MODULATOR:  data_line = modulator_ok & modulator_src; // [RL13]
            default:          data_line = 1'b0;                // [RL14]
        endcase
    end

endmodule // source_mux

`default_nettype wire

// File: hw/logic_cell_input_select.v
// Purpose: Input data selection stage of the configurable logic cell
// Assumes: One clock, synchronous active-low reset, no register bus
// Notes:   Four selection registers steer four multiplexers
//          Lines to the gating stage are combinational
//          Codes with no source give a constant zero
//
// Operation
// [RL1] First of four cell stages; feeds the data-gating stage.
// [RL2] Selections are rewritable at run time without stopping the cell.
// [RL3] Four independent multiplexers, each picks one shared internal input.
// [RL4] Each multiplexer steered by its own 6-bit select field.
// [RL5] Four separate writable selection registers, zero through three.
// [RL6] Software must program selections before use; power-up value undefined. Reset here loads 00h into each register.
// [RL7] Codes 25h,24h,23h,22h pick system, fast, slow, converter clocks.
// [RL8] Codes 1Eh,1Fh,20h pick timer 2, 4, 6 postscaled pulses.
// [RL9] Codes 1Ah to 1Dh pick timer 0, 1, 3, 5 overflows.
// [RL10] Code 21h picks the pin-change flag set state.
// [RL11] Codes 18h,19h async transmit, receive; 16h sync serial data.
// [RL12] Code 17h picks the zero-cross detector output.
// [RL13] Code 26h picks modulator one or two per instance, else reserved.
// [RL14] Unlisted or unsupported codes drive constant zero.
// [RL15] Outputs follow the selected source with no clock latency.
`include "cell_select_consts.vh"
`default_nettype none

module logic_cell_input_select #(
    parameter [1:0] MOD_SRC = `MOD_ONE
) (
    // Clock and reset
    input  wire        clk,
    input  wire        rstn,
    // Selection register writes
    input  wire [3:0]  sel_wr_en,
    input  wire [5:0]  sel_wr_data,
    // Selection readback
    output wire [5:0]  input_select_reg_zero,
    output wire [5:0]  input_select_reg_one,
    output wire [5:0]  input_select_reg_two,
    output wire [5:0]  input_select_reg_three,
    // Clock sources
    input  wire        sys_osc,
    input  wire        fast_internal_osc,
    input  wire        slow_internal_osc,
    input  wire        converter_rc_clock,
    // Flag and timer sources
    input  wire        pin_change_flag,
    input  wire        tmr2_post,
    input  wire        tmr4_post,
    input  wire        tmr6_post,
    input  wire        tmr0_ovf,
    input  wire        tmr1_ovf,
    input  wire        tmr3_ovf,
    input  wire        tmr5_ovf,
    // Serial and sensing sources
    input  wire        async_tx,
    input  wire        async_rx,
    input  wire        sync_data,
    input  wire        zero_cross_detector,
    // Modulator sources
    input  wire        modulator_one_output,
    input  wire        modulator_two_output,
    // Lines to the gating stage
    output wire [3:0]  gate_data                     // [RL1]
);

    ////////////////////////////////////////////////////////////////////////
    // Selection registers and multiplexers

    // Stored select code per lane
    wire [5:0]  sel_zero;
    wire [5:0]  sel_one;
    wire [5:0]  sel_two;
    wire [5:0]  sel_three;
    // Per-lane write strobes
    wire        wr_zero;
    wire        wr_one;
    wire        wr_two;
    wire        wr_three;
    // Modulator source shared by all lanes
    reg         mod_src;
    reg         mod_ok;

    // One strobe bit per selection register
    assign wr_zero  = sel_wr_en[0];                                 // [RL5]
    assign wr_one   = sel_wr_en[1];                                 // [RL5]
    assign wr_two   = sel_wr_en[2];                                 // [RL5]
    assign wr_three = sel_wr_en[3];                                 // [RL5]

    // Modulator choice fixed per instance; none leaves code 26h reserved
    always @* begin
        case (MOD_SRC)
            `MOD_ONE: begin
                mod_src = modulator_one_output;                     // [RL13]
                mod_ok  = 1'b1;
            end
            `MOD_TWO: begin
                mod_src = modulator_two_output;                     // [RL13]
                mod_ok  = 1'b1;
            end
            default: begin
                mod_src = 1'b0;
                mod_ok  = 1'b0;                                     // [RL13]
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Lane zero

    // Register zero, reloads on any write with no stop
    select_reg u_reg_zero (
        // Clock and reset
        .clk     (clk),
        .rstn    (rstn),
        // Write side
        .wr_en   (wr_zero),                 // [RL2]
        .wr_data (sel_wr_data),
        // Stored field
        .sel_r   (sel_zero)                 // [RL4]
    );

    // Multiplexer zero, combinational path to the gating stage
    source_mux u_mux_zero (
        // Selection
        .mux_select_field    (sel_zero),
        // Clock sources
        .sys_osc             (sys_osc),
        .fast_internal_osc   (fast_internal_osc),
        .slow_internal_osc   (slow_internal_osc),
        .converter_rc_clock  (converter_rc_clock),
        // Flag source
        .pin_change_flag     (pin_change_flag),
        // Timer sources
        .tmr2_post           (tmr2_post),
        .tmr4_post           (tmr4_post),
        .tmr6_post           (tmr6_post),
        .tmr0_ovf            (tmr0_ovf),
        .tmr1_ovf            (tmr1_ovf),
        .tmr3_ovf            (tmr3_ovf),
        .tmr5_ovf            (tmr5_ovf),
        // Serial and sensing sources
        .async_tx            (async_tx),
        .async_rx            (async_rx),
        .sync_data           (sync_data),
        .zero_cross_detector (zero_cross_detector),
        // Modulator source
        .modulator_src       (mod_src),
        .modulator_ok        (mod_ok),
        // Selected line
        .data_line           (gate_data[0])   // [RL3] [RL15]
    );

    ////////////////////////////////////////////////////////////////////////
    // Lane one

    // Register one, reloads on any write with no stop
    select_reg u_reg_one (
        // Clock and reset
        .clk     (clk),
        .rstn    (rstn),
        // Write side
        .wr_en   (wr_one),                  // [RL2]
        .wr_data (sel_wr_data),
        // Stored field
        .sel_r   (sel_one)                  // [RL4]
    );

    // Multiplexer one, combinational path to the gating stage
    source_mux u_mux_one (
        // Selection
        .mux_select_field    (sel_one),
        // Clock sources
        .sys_osc             (sys_osc),
        .fast_internal_osc   (fast_internal_osc),
        .slow_internal_osc   (slow_internal_osc),
        .converter_rc_clock  (converter_rc_clock),
        // Flag source
        .pin_change_flag     (pin_change_flag),
        // Timer sources
        .tmr2_post           (tmr2_post),
        .tmr4_post           (tmr4_post),
        .tmr6_post           (tmr6_post),
        .tmr0_ovf            (tmr0_ovf),
        .tmr1_ovf            (tmr1_ovf),
        .tmr3_ovf            (tmr3_ovf),
        .tmr5_ovf            (tmr5_ovf),
        // Serial and sensing sources
        .async_tx            (async_tx),
        .async_rx            (async_rx),
        .sync_data           (sync_data),
        .zero_cross_detector (zero_cross_detector),
        // Modulator source
        .modulator_src       (mod_src),
        .modulator_ok        (mod_ok),
        // Selected line
        .data_line           (gate_data[1])   // [RL3] [RL15]
    );

    ////////////////////////////////////////////////////////////////////////
    // Lane two

    // Register two, reloads on any write with no stop
    select_reg u_reg_two (
        // Clock and reset
        .clk     (clk),
        .rstn    (rstn),
        // Write side
        .wr_en   (wr_two),                  // [RL2]
        .wr_data (sel_wr_data),
        // Stored field
        .sel_r   (sel_two)                  // [RL4]
    );

    // Multiplexer two, combinational path to the gating stage
    source_mux u_mux_two (
        // Selection
        .mux_select_field    (sel_two),
        // Clock sources
        .sys_osc             (sys_osc),
        .fast_internal_osc   (fast_internal_osc),
        .slow_internal_osc   (slow_internal_osc),
        .converter_rc_clock  (converter_rc_clock),
        // Flag source
        .pin_change_flag     (pin_change_flag),
        // Timer sources
        .tmr2_post           (tmr2_post),
        .tmr4_post           (tmr4_post),
        .tmr6_post           (tmr6_post),
        .tmr0_ovf            (tmr0_ovf),
        .tmr1_ovf            (tmr1_ovf),
        .tmr3_ovf            (tmr3_ovf),
        .tmr5_ovf            (tmr5_ovf),
        // Serial and sensing sources
        .async_tx            (async_tx),
        .async_rx            (async_rx),
        .sync_data           (sync_data),
        .zero_cross_detector (zero_cross_detector),
        // Modulator source
        .modulator_src       (mod_src),
        .modulator_ok        (mod_ok),
        // Selected line
        .data_line           (gate_data[2])   // [RL3] [RL15]
    );

    ////////////////////////////////////////////////////////////////////////
    // Lane three

    // Register three, reloads on any write with no stop
    select_reg u_reg_three (
        // Clock and reset
        .clk     (clk),
        .rstn    (rstn),
        // Write side
        .wr_en   (wr_three),                // [RL2]
        .wr_data (sel_wr_data),
        // Stored field
        .sel_r   (sel_three)                // [RL4]
    );

    // Multiplexer three, combinational path to the gating stage
    source_mux u_mux_three (
        // Selection
        .mux_select_field    (sel_three),
        // Clock sources
        .sys_osc             (sys_osc),
        .fast_internal_osc   (fast_internal_osc),
        .slow_internal_osc   (slow_internal_osc),
        .converter_rc_clock  (converter_rc_clock),
        // Flag source
        .pin_change_flag     (pin_change_flag),
        // Timer sources
        .tmr2_post           (tmr2_post),
        .tmr4_post           (tmr4_post),
        .tmr6_post           (tmr6_post),
        .tmr0_ovf            (tmr0_ovf),
        .tmr1_ovf            (tmr1_ovf),
        .tmr3_ovf            (tmr3_ovf),
        .tmr5_ovf            (tmr5_ovf),
        // Serial and sensing sources
        .async_tx            (async_tx),
        .async_rx            (async_rx),
        .sync_data           (sync_data),
        .zero_cross_detector (zero_cross_detector),
        // Modulator source
        .modulator_src       (mod_src),
        .modulator_ok        (mod_ok),
        // Selected line
        .data_line           (gate_data[3])   // [RL3] [RL15]
    );

    ////////////////////////////////////////////////////////////////////////
    // Readback straight from the selection flops

    assign input_select_reg_zero  = sel_zero;
    assign input_select_reg_one   = sel_one;
    assign input_select_reg_two   = sel_two;
    assign input_select_reg_three = sel_three;

endmodule // logic_cell_input_select

`default_nettype wire

// File: test/source_model.sv
// Purpose: Peripheral source model
// Assumes: Sources change on clk
// Notes:   Bit k is code 16h+k, 16 and 17 modulators
`default_nettype none
module source_model (
    // Pattern in, sources out
    input  wire logic        clk,
    input  wire logic [17:0] pat,
    output var  logic [17:0] src
);
    timeunit 1ns;
    timeprecision 100ps;
    // Levels move on clk
    always @(posedge clk) src <= pat;
endmodule // source_model
`default_nettype wire

// File: test/cell_select_assertions.sv
// Purpose: Port checker for the selection stage
// Assumes: Default modulator one
// Notes:   Lanes 0 and 1 watched
`default_nettype none
module cell_select_checker #(
    parameter [1:0] MOD_SRC = 2'h1
) (
    // Clock, reset, writes
    input wire logic       clk,
    input wire logic       rstn,
    input wire logic [3:0] sel_wr_en,
    input wire logic [5:0] sel_wr_data,
    // Codes, lines, sources
    input wire logic [5:0] input_select_reg_zero,
    input wire logic [5:0] input_select_reg_one,
    input wire logic [3:0] gate_data,
    input wire logic       async_tx,
    input wire logic       sys_osc,
    input wire logic       pin_change_flag,
    input wire logic       modulator_one_output,
    input wire logic       modulator_two_output
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    a_lane_write: assert property (rstn && sel_wr_en[0]
        |=> input_select_reg_zero == $past(sel_wr_data)) else $error("write lost");
    a_lane_hold: assert property (rstn && !sel_wr_en[1]
        |=> $stable(input_select_reg_one)) else $error("code changed");
    a_reset_clear: assert property (disable iff (1'b0) !rstn
        |=> input_select_reg_zero == 6'h00) else $error("reset value");
    a_tx_route: assert property (input_select_reg_zero == 6'h18
        |-> gate_data[0] == async_tx) else $error("tx route");
    a_osc_route: assert property (input_select_reg_one == 6'h25
        |-> gate_data[1] == sys_osc) else $error("osc route");
    a_flag_route: assert property (input_select_reg_one == 6'h21
        |-> gate_data[1] == pin_change_flag) else $error("flag route");
    a_mod_route: assert property (input_select_reg_zero == 6'h26
        |-> gate_data[0] == ((MOD_SRC == 2'h2) ? modulator_two_output
            : ((MOD_SRC == 2'h1) && modulator_one_output))) else $error("mod");
    a_unused_zero: assert property (input_select_reg_one > 6'h26
        |-> !gate_data[1]) else $error("unused code");
endmodule // cell_select_checker
bind logic_cell_input_select cell_select_checker #(.MOD_SRC(MOD_SRC)) chk_u (
    .clk, .rstn, .sel_wr_en, .sel_wr_data, .input_select_reg_zero, .input_select_reg_one,
    .gate_data, .async_tx, .sys_osc, .pin_change_flag, .modulator_one_output,
    .modulator_two_output);
`default_nettype wire

// File: test/logic_cell_input_select_tb.sv
// Purpose: Bench for the selection stage
// Assumes: Partner drives the sources
// Notes:   Every code on every lane
`default_nettype none
module logic_cell_input_select_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic [3:0]  sel_wr_en = 4'h0;
    logic [5:0]  sel_wr_data = 6'h00;
    logic [17:0] pat = 18'h00000;
    wire  [17:0] src;
    wire  [5:0]  rg [0:3];
    wire  [3:0]  gate_data;
    int          err_total = 0;
    int          n_checks = 0;
    source_model src_u (.clk, .pat, .src);
    logic_cell_input_select #(.MOD_SRC(2'h1)) dut_u (
        .clk, .rstn, .sel_wr_en, .sel_wr_data, .gate_data,
        .input_select_reg_zero(rg[0]), .input_select_reg_one(rg[1]),
        .input_select_reg_two(rg[2]), .input_select_reg_three(rg[3]),
        .sync_data(src[0]), .zero_cross_detector(src[1]), .async_tx(src[2]),
        .async_rx(src[3]), .tmr0_ovf(src[4]), .tmr1_ovf(src[5]), .tmr3_ovf(src[6]),
        .tmr5_ovf(src[7]), .tmr2_post(src[8]), .tmr4_post(src[9]), .tmr6_post(src[10]),
        .pin_change_flag(src[11]), .converter_rc_clock(src[12]),
        .slow_internal_osc(src[13]), .fast_internal_osc(src[14]), .sys_osc(src[15]),
        .modulator_one_output(src[16]), .modulator_two_output(src[17]));
    ////////////////////////////////
    function automatic logic exp_bit(input logic [5:0] c, input logic [17:0] p);
        if (c >= 6'h16 && c <= 6'h25) return p[c - 6'h16];
        return (c == 6'h26) ? p[16] : 1'b0;
    endfunction
    task automatic chk_gate(input logic [3:0] e);
        n_checks++;
        if (gate_data !== e) begin
            err_total++;
            $display("CHECK FAILED %0t gate %h exp %h", $time, gate_data, e);
        end
    endtask
    task automatic chk_code(input int i, input logic [5:0] e);
        n_checks++;
        if (rg[i] !== e) begin
            err_total++;
            $display("CHECK FAILED %0t lane %0d code %h", $time, i, rg[i]);
        end
    endtask
    task automatic wr(input logic [3:0] m, input logic [5:0] c);
        @(posedge clk);
        sel_wr_en <= m;
        sel_wr_data <= c;
    endtask
    task automatic idle;
        @(posedge clk);
        sel_wr_en <= 4'h0;
        #1;
    endtask
    task automatic set_pat(input logic [17:0] p);
        @(posedge clk);
        pat <= p;
        @(posedge clk);
        #1;
    endtask
    ////////////////////////////////
    task automatic test_reset;
        set_pat(18'h3FFFF);
        for (int i = 0; i < 4; i++) chk_code(i, 6'h00);
        chk_gate(4'h0);
        $display("test_reset done");
    endtask
    task automatic test_codes;
        for (int c = 0; c < 64; c++) begin
            wr(4'hF, 6'(c));
            idle();
            for (int i = 0; i < 4; i++) chk_code(i, 6'(c));
            set_pat(18'h15A5A);
            chk_gate({4{exp_bit(6'(c), 18'h15A5A)}});
            set_pat(18'h2A5A5);
            chk_gate({4{exp_bit(6'(c), 18'h2A5A5)}});
        end
        $display("test_codes done");
    endtask
    task automatic test_lanes;
        wr(4'h1, 6'h18);
        wr(4'h2, 6'h1E);
        wr(4'h4, 6'h25);
        wr(4'h8, 6'h21);
        idle();
        chk_code(0, 6'h18);
        chk_code(3, 6'h21);
        set_pat(18'h08004);
        chk_gate(4'h5);
        set_pat(18'h00900);
        chk_gate(4'hA);
        wr(4'h4, 6'h3F);
        idle();
        set_pat(18'h08900);
        chk_gate(4'hA);
        @(posedge clk);
        rstn <= 1'b0;
        @(posedge clk);
        rstn <= 1'b1;
        #1;
        chk_code(1, 6'h00);
        chk_gate(4'h0);
        $display("test_lanes done");
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    ////////////////////////////////
    // Clock, watchdog, main sequence
    initial forever #2 clk = ~clk;
    initial begin
        #20000;
        err_total++;
        end_sim();
    end
    initial begin
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        test_reset();
        test_codes();
        test_lanes();
        end_sim();
    end
endmodule // logic_cell_input_select_tb
`default_nettype wire
